// ### byte_skid_if.sv
/*
  Interface carrying a valid/ready stream between the top module and its
  two-entry buffer. Assumes one clock shared by both sides.
*/
`timescale 1ns/1ps
interface byte_skid_if #(parameter int W = 16);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport buf_side (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport user_side (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
endinterface

// ### instruction_prefetch_queue.sv
/*
  Bus interface unit with six-byte instruction prefetch queue, serving an
  execution unit. Memory side is a simple request/acknowledge word port on
  the same clock; fetched words pass a two-entry buffer so a memory stall or a
  full queue loses no word.
*/
// Contract
// - Queue holds at most six instruction bytes and refuses more when full.
// - With room for two or more bytes, a word fetch is attempted.
// - Bytes leave in fetch order, one at a time on demand.
// - Into an empty queue, the first byte is available at once; here it reaches the output two edges after the buffer takes the word.
// - Bus side and execution side run concurrently and independently.
// - Bus side performs fetches, operand reads, writes, relocation, bus control.
// - Execution side gives unrelocated addresses; bus side relocates them.
// - Read operands go to execution side; results come back for storage.
`timescale 1ns/1ps
module instruction_prefetch_queue
  import prefetch_pkg::*;
#(
  parameter int DEPTH = QUEUE_BYTES
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Execution unit side
  input wire logic byte_take_in,
  output logic byte_valid_out,
  output logic [7:0] byte_data_out,
  input wire logic branch_in,
  input wire logic [15:0] branch_seg_in,
  input wire logic [15:0] branch_ip_in,
  input wire logic op_req_in,
  input wire logic op_write_in,
  input wire logic [15:0] op_seg_in,
  input wire logic [15:0] op_offs_in,
  input wire logic [15:0] op_wdata_in,
  output logic op_done_out,
  output logic [15:0] op_rdata_out,
  // Memory bus side
  output logic mem_req_out,
  output logic mem_write_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  function automatic logic [ADDR_W-1:0] relocate(input logic [15:0] seg,
                                                 input logic [15:0] offs);
    relocate = ADDR_W'({seg, 4'h0}) + ADDR_W'(offs);
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  bus_state_type state_r;
  logic [15:0] seg_r;
  logic [15:0] ip_r;
  logic [7:0] q_r [DEPTH];
  logic [PW-1:0] qwp_r;
  logic [PW-1:0] qrp_r;
  logic [CW-1:0] qcnt_r;
  logic [CW-1:0] inflight_r;
  logic drop_r;
  logic half_r;
  logic [7:0] out_byte_r;
  logic out_valid_r;
  logic op_done_r;
  logic [15:0] op_rdata_r;
  logic mem_req_r;
  logic mem_write_r;
  logic [ADDR_W-1:0] mem_addr_r;
  logic [15:0] mem_wdata_r;

  byte_skid_if #(.W(16)) skid ();
  skid_buffer #(.W(16)) u_skid (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .flush_in(branch_in),
    .port(skid.buf_side)
  );

  // Fetch words land in the buffer; operand reads bypass it
  assign skid.in_valid = mem_ack_in && (state_r == bus_fetch_type_s) && !drop_r;
  assign skid.in_data = mem_rdata_in;

  // Byte stream: fill from buffer two bytes per word (low byte first)
  wire out_pop = out_valid_r && byte_take_in;
  wire q_empty = (qcnt_r == '0);
  wire [CW-1:0] q_space = CW'(DEPTH) - qcnt_r;
  wire load_word = skid.out_valid && (q_space >= CW'(FETCH_ROOM));
  assign skid.out_ready = load_word;
  wire out_room = !out_valid_r || out_pop;
  wire q_pop = out_room && !q_empty;
  wire [CW-1:0] occ = qcnt_r + CW'(out_valid_r) + inflight_r
                      + (skid.out_valid ? CW'(2) : '0);
  // Output byte counts as queued; limit form keeps the narrow sum from wrapping
  wire can_fetch = (occ <= CW'(DEPTH - FETCH_ROOM)) && !branch_in;
  wire [ADDR_W-1:0] fetch_addr = relocate(seg_r, ip_r);
  wire [ADDR_W-1:0] op_addr = relocate(op_seg_in, op_offs_in);

  // Byte queue storage, fed by words, drained one byte at a time
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      qwp_r <= '0;
      qrp_r <= '0;
      qcnt_r <= '0;
      out_valid_r <= 1'b0;
      out_byte_r <= 8'h00;
    end else if (branch_in) begin
      qwp_r <= '0;
      qrp_r <= '0;
      qcnt_r <= '0;
      out_valid_r <= 1'b0;
    end else begin
      if (load_word) begin
        q_r[qwp_r] <= skid.out_data[7:0];
        q_r[ptr_inc(qwp_r)] <= skid.out_data[15:8];
        qwp_r <= ptr_inc(ptr_inc(qwp_r));
      end
      if (q_pop) begin
        out_byte_r <= q_r[qrp_r];
        qrp_r <= ptr_inc(qrp_r);
      end
      // Empty queue: a buffered word loads on one edge, its first byte reaches the output stage the edge after
      if (q_pop) begin
        out_valid_r <= 1'b1;
      end else if (out_pop) begin
        out_valid_r <= 1'b0;
      end
      qcnt_r <= qcnt_r + (load_word ? CW'(2) : '0) - CW'(q_pop);
    end
  end

  // Bus sequencer: operands outrank prefetch, runs alongside execution
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= bus_idle_type_s;
      seg_r <= RESET_SEG;
      ip_r <= RESET_IP;
      inflight_r <= '0;
      drop_r <= 1'b0;
      half_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_write_r <= 1'b0;
      mem_addr_r <= '0;
      mem_wdata_r <= 16'h0000;
      op_done_r <= 1'b0;
      op_rdata_r <= 16'h0000;
    end else begin
      op_done_r <= 1'b0;
      half_r <= 1'b0;
      if (branch_in) begin
        seg_r <= branch_seg_in;
        ip_r <= branch_ip_in;
        inflight_r <= '0;
        // Fetch on the bus still ends, its word discarded; a taken ack clears this
        if (state_r == bus_fetch_type_s) begin
          drop_r <= 1'b1;
        end
      end
      case (state_r)
        bus_idle_type_s: begin
          if (op_req_in && !op_done_r) begin
            mem_req_r <= 1'b1;
            mem_write_r <= op_write_in;
            mem_addr_r <= op_addr;
            mem_wdata_r <= op_wdata_in;
            state_r <= op_write_in ? bus_write_type_s : bus_read_type_s;
          end else if (can_fetch && skid.in_ready) begin
            mem_req_r <= 1'b1;
            mem_write_r <= 1'b0;
            mem_addr_r <= fetch_addr;
            inflight_r <= CW'(2);
            drop_r <= 1'b0;
            state_r <= bus_fetch_type_s;
          end
        end
        bus_fetch_type_s: begin
          if (mem_ack_in && (skid.in_ready || drop_r)) begin
            mem_req_r <= 1'b0;
            drop_r <= 1'b0;
            if (!branch_in) begin
              inflight_r <= '0;
              if (!drop_r) begin
                ip_r <= ip_r + 16'h0002;
              end
            end
            state_r <= bus_idle_type_s;
          end
        end
        bus_read_type_s, bus_write_type_s: begin
          if (mem_ack_in) begin
            mem_req_r <= 1'b0;
            mem_write_r <= 1'b0;
            op_done_r <= 1'b1;
            if (state_r == bus_read_type_s) begin
              op_rdata_r <= mem_rdata_in;
            end
            state_r <= bus_idle_type_s;
          end
        end
        default: begin
          state_r <= bus_idle_type_s;
        end
      endcase
    end
  end

  assign byte_valid_out = out_valid_r;
  assign byte_data_out = out_byte_r;
  assign op_done_out = op_done_r;
  assign op_rdata_out = op_rdata_r;
  assign mem_req_out = mem_req_r;
  assign mem_write_out = mem_write_r;
  assign mem_addr_out = mem_addr_r;
  assign mem_wdata_out = mem_wdata_r;
endmodule

// ### instruction_prefetch_queue_bench.sv
/*
  Self-checking bench: byte stream, fill limit, branches, operands.
  Assumes mem_model as memory and a 40 MHz clock.
*/
`timescale 1ns/1ps
module instruction_prefetch_queue_bench;
  import prefetch_pkg::*;
  logic clk_sys_in, byte_valid_out, op_done_out, mem_req_out, mem_write_out, mem_ack_in;
  logic rst_b_in = 1'b0, byte_take_in = 1'b0, branch_in = 1'b0, op_req_in = 1'b0;
  logic op_write_in = 1'b0, rnd_on = 1'b0, force_take = 1'b0;
  logic [15:0] branch_seg_in = 16'h0, branch_ip_in = 16'h0, op_seg_in = 16'h0;
  logic [15:0] op_offs_in = 16'h0, op_wdata_in = 16'h0;
  logic [15:0] op_rdata_out, mem_wdata_out, mem_rdata_in, wr_data;
  logic [7:0] byte_data_out;
  logic [19:0] mem_addr_out, wr_addr, a, exp_a = {RESET_SEG, 4'h0} + {4'h0, RESET_IP};
  int error_cnt = 0, cmp_count = 0, i, n;
  instruction_prefetch_queue dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .byte_take_in(byte_take_in), .byte_valid_out(byte_valid_out),
    .byte_data_out(byte_data_out), .branch_in(branch_in), .branch_seg_in(branch_seg_in),
    .branch_ip_in(branch_ip_in), .op_req_in(op_req_in), .op_write_in(op_write_in),
    .op_seg_in(op_seg_in), .op_offs_in(op_offs_in), .op_wdata_in(op_wdata_in),
    .op_done_out(op_done_out), .op_rdata_out(op_rdata_out), .mem_req_out(mem_req_out),
    .mem_write_out(mem_write_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));
  mem_model mem_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .req_in(mem_req_out),
    .write_in(mem_write_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in), .wr_addr_out(wr_addr), .wr_data_out(wr_data));
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_word(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys_in) byte_take_in <= force_take | (rnd_on & ($urandom % 2 == 0));
  // Model: next byte is the low byte of the next linear address
  always @(posedge clk_sys_in) begin
    if (rst_b_in && branch_in) exp_a = {branch_seg_in, 4'h0} + {4'h0, branch_ip_in};
    else if (rst_b_in && byte_valid_out && byte_take_in) begin
      chk_byte(byte_data_out, exp_a[7:0]);
      exp_a = exp_a + 20'h1;
    end
  end
  task take_one;
    @(negedge clk_sys_in) force_take = 1'b1;
    @(negedge clk_sys_in) force_take = 1'b0;
  endtask
  initial begin
    i = $urandom(86622);
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(negedge clk_sys_in) rnd_on = 1'b1;
    repeat (400) @(posedge clk_sys_in);
    $display("test 1 done");
    @(negedge clk_sys_in) rnd_on = 1'b0;
    // Flush first so the fill starts from empty and the byte count is known
    @(posedge clk_sys_in);
    branch_seg_in <= 16'($urandom);
    branch_ip_in <= 16'($urandom) & 16'h7FFE;
    branch_in <= 1'b1;
    @(posedge clk_sys_in) branch_in <= 1'b0;
    repeat (40) @(posedge clk_sys_in);
    chk_word(20'(mem_req_out), 20'h0);
    take_one();
    repeat (8) @(posedge clk_sys_in);
    chk_word(20'(mem_req_out), 20'h0);
    take_one();
    for (n = 0; n < 10 && mem_req_out !== 1'b1; n++) @(posedge clk_sys_in);
    chk_word(20'(mem_req_out), 20'h1);
    $display("test 2 done");
    @(negedge clk_sys_in) rnd_on = 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys_in);
      branch_seg_in <= 16'($urandom);
      branch_ip_in <= 16'($urandom) & 16'h7FFE;
      branch_in <= 1'b1;
      @(posedge clk_sys_in) branch_in <= 1'b0;
      repeat (60) @(posedge clk_sys_in);
    end
    $display("test 3 done");
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys_in);
      op_write_in <= i[0];
      op_seg_in <= 16'($urandom);
      op_offs_in <= 16'($urandom) & 16'hFFFE;
      op_wdata_in <= 16'($urandom);
      op_req_in <= 1'b1;
      for (n = 0; n < 40 && op_done_out !== 1'b1; n++) @(posedge clk_sys_in);
      if (n == 40) begin
        error_cnt++;
        end_sim();
      end
      op_req_in <= 1'b0;
      a = {op_seg_in, 4'h0} + {4'h0, op_offs_in};
      if (op_write_in) chk_word(wr_addr, a);
      if (op_write_in) chk_word(20'(wr_data), 20'(op_wdata_in));
      else chk_word(20'(op_rdata_out), 20'({a[7:0] + 8'h01, a[7:0]}));
    end
    $display("test 4 done");
    end_sim();
  end
endmodule

// ### ipq_properties.sv
/*
  Port-level checker for the prefetch queue top module.
  Assumes one clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ipq_properties
  import prefetch_pkg::*;
#(
  parameter int DEPTH = QUEUE_BYTES
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic byte_take_in,
  input wire logic byte_valid_out,
  input wire logic [7:0] byte_data_out,
  input wire logic branch_in,
  input wire logic [15:0] op_seg_in,
  input wire logic [15:0] op_offs_in,
  input wire logic [15:0] op_wdata_in,
  input wire logic op_done_out,
  input wire logic mem_req_out,
  input wire logic mem_write_out,
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic mem_ack_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  a_reset_fetch: assert property ($rose(rst_b_in) |=> mem_req_out
    && mem_addr_out == ({RESET_SEG, 4'h0} + {4'h0, RESET_IP}))
    else $error("No fetch after reset");
  a_req_stand: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("Request dropped early");
  a_write_drop: assert property (mem_req_out && mem_ack_in && mem_write_out |=> !mem_req_out)
    else $error("Write not ended");
  a_write_reloc: assert property (mem_req_out && mem_write_out |-> mem_wdata_out == op_wdata_in
    && mem_addr_out == {op_seg_in, 4'h0} + {4'h0, op_offs_in})
    else $error("Bad write address or data");
  a_done_ack: assert property ($rose(op_done_out) |-> $past(mem_ack_in) && $past(mem_req_out))
    else $error("Done without ack");
  a_done_pulse: assert property (op_done_out |=> !op_done_out)
    else $error("Done too long");
  a_byte_stand: assert property (byte_valid_out && !byte_take_in && !branch_in
    |=> byte_valid_out && $stable(byte_data_out))
    else $error("Byte lost while waiting");
  a_branch_flush: assert property (branch_in |=> !byte_valid_out)
    else $error("Stale byte after branch");
  a_first_byte: assert property (branch_in |-> ##[2:40] byte_valid_out)
    else $error("No byte after branch");
  c_overlap: cover property (byte_valid_out && byte_take_in && mem_req_out);
  c_write: cover property (mem_req_out && mem_ack_in && mem_write_out);
  c_branch: cover property (branch_in ##1 !byte_valid_out);
endmodule
bind instruction_prefetch_queue ipq_properties #(.DEPTH(DEPTH)) chk_u (
  .clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in),
  .byte_take_in(byte_take_in),
  .byte_valid_out(byte_valid_out),
  .byte_data_out(byte_data_out),
  .branch_in(branch_in),
  .op_seg_in(op_seg_in),
  .op_offs_in(op_offs_in),
  .op_wdata_in(op_wdata_in),
  .op_done_out(op_done_out),
  .mem_req_out(mem_req_out),
  .mem_write_out(mem_write_out),
  .mem_addr_out(mem_addr_out),
  .mem_wdata_out(mem_wdata_out),
  .mem_ack_in(mem_ack_in)
);

// ### mem_model.sv
/*
  Memory behind the bus side: answers after 0 to 3 wait cycles.
  Assumes word data {a+1, a} from the low address byte a.
*/
`timescale 1ns/1ps
module mem_model (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [19:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic ack_out,
  output logic [15:0] rdata_out,
  output logic [19:0] wr_addr_out,
  output logic [15:0] wr_data_out
);
  logic [1:0] wait_r;
  logic [15:0] junk_r;
  // Idle data churns so a stale word never matches by luck
  assign rdata_out = ack_out ? {addr_in[7:0] + 8'h01, addr_in[7:0]} : junk_r;
  always @(posedge clk_sys_in) junk_r <= 16'($urandom);
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= 1'b0;
      wait_r <= 2'h0;
    end else if (ack_out) begin
      ack_out <= req_in;
    end else if (req_in && wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else if (req_in) begin
      ack_out <= 1'b1;
      wait_r <= 2'($urandom);
      if (write_in) begin
        wr_addr_out <= addr_in;
        wr_data_out <= wdata_in;
      end
    end
  end
endmodule

// ### prefetch_pkg.sv
/*
  Shared constants and types for the instruction prefetch queue and its
  bus interface side. Assumes a 16-bit data path and 20-bit physical addresses.
*/
package prefetch_pkg;
  localparam int QUEUE_BYTES = 6;
  localparam int ADDR_W = 20;
  localparam int OFFS_W = 16;
  localparam int SEG_SHIFT = 4;
  localparam int FETCH_ROOM = 2;
  localparam logic [15:0] RESET_SEG = 16'hFFFF;
  localparam logic [15:0] RESET_IP = 16'h0000;
  typedef enum logic [1:0] {
    bus_idle_type_s,
    bus_fetch_type_s,
    bus_read_type_s,
    bus_write_type_s
  } bus_state_type;
endpackage

// ### skid_buffer.sv
/*
  Two-entry buffer with valid/ready on both sides; read data leave a register.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module skid_buffer
  import prefetch_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic flush_in,
  byte_skid_if.buf_side port
);
  logic [W-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = port.in_valid && port.in_ready;
  wire pop = port.out_valid && port.out_ready;
  assign port.in_ready = (cnt_r != 2'h2);
  assign port.out_valid = (cnt_r != 2'h0);
  assign port.out_data = mem_r[rp_r];
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (flush_in) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r <= wp_r ^ push;
      rp_r <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wp_r] <= port.in_data;
    end
  end
endmodule
